//--- hdl/ipc_ctrl.sv
// Purpose: decode the isolated command input and drive the gate output
// Assumes: comparator and supply status inputs are synchronous to clk_in
// Notes: long counts are module parameters so a simulation can shorten them
// Summary of operation
// - low command input drives gate high
// - external commands gate only with regulator off
// - sleep commands need active part, supply ok
// - comparator change ends on-time until next command
// - live pwm stream selects normal run mode
// - idle high past timeout returns to start-up
// - idle low: gate until trip, then timeout
// - five fast falling edges mean sleep
// - sleep blocks internal regulator gating
// - pwm resumed in sleep enters normal run
// - single pulse ends sleep, timeout then start-up
// - sleep keeps linear regulator off until wake
// - supply high enables start-up with regulator on or off
// - sleep accepted from either supply source
// - burst-rate oscillator disabled during normal run
// - start-up off-time fixed after each trip
// - sixteen start-up pulses per oscillator period
`timescale 1ns/1ps
module ipc_ctrl #(
    parameter int TIMEOUT_CYC = ipc_pkg::TIMEOUT_CYC,
    parameter int OFF_TIME_CYC = ipc_pkg::OFF_TIME_CYC,
    parameter int LFO_PERIOD_CYC = ipc_pkg::LFO_PERIOD_CYC,
    parameter int BURST_GAP_CYC = ipc_pkg::BURST_GAP_CYC
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // command input from isolator, active low
    input wire logic cmd_n_in,
    // comparators and supply status
    input wire logic peak_limit_trip_in,
    input wire logic ccm_guard_trip_in,
    input wire ipc_pkg::ipc_supply_t supply_in,
    // outputs
    output logic gate_out,
    output logic regulator_enable_out,
    output logic burst_rate_oscillator_en_out,
    output ipc_pkg::ipc_mode_t mode_out
);
    localparam int CW = $clog2(LFO_PERIOD_CYC + TIMEOUT_CYC + 2);

    logic cmd_s1_r, cmd_s2_r, cmd_d_r;
    logic trip_d_r;
    logic [CW-1:0] idle_r, off_r, lfo_r;
    logic [CW-1:0] gap_r;
    logic [2:0] edges_r;
    logic [4:0] pulses_r;
    logic run_gate_r, su_gate_r;
    logic sleep_wake_r;
    ipc_pkg::ipc_mode_t mode_r, mode_nxt;

    wire trip_now = peak_limit_trip_in | ccm_guard_trip_in;
    wire trip_change = trip_now ^ trip_d_r;
    wire fall = cmd_d_r & ~cmd_s2_r;
    wire toggle = cmd_d_r ^ cmd_s2_r;
    wire timed_out = (idle_r >= CW'(TIMEOUT_CYC));
    wire cmd_valid = supply_in.supply_ok;
    wire ext_ok = ~supply_in.regulator_on;
    wire burst_hit = fall & (gap_r < CW'(BURST_GAP_CYC)) &
        (edges_r == 3'(ipc_pkg::BURST_EDGES - 1));
    wire lfo_wrap = (lfo_r >= CW'(LFO_PERIOD_CYC - 1));
    wire su_window = (pulses_r < 5'(ipc_pkg::BURST_PULSES));

    // synchroniser first stage feeds only the second
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cmd_s1_r <= 1'b1;
            cmd_s2_r <= 1'b1;
            cmd_d_r <= 1'b1;
            trip_d_r <= 1'b0;
        end else begin
            cmd_s1_r <= cmd_n_in;
            cmd_s2_r <= cmd_s1_r;
            cmd_d_r <= cmd_s2_r;
            trip_d_r <= trip_now;
        end
    end

    // idle timer and burst edge counter
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            idle_r <= '0;
            gap_r <= '0;
            edges_r <= '0;
        end else begin
            idle_r <= toggle ? '0 : (timed_out ? idle_r : idle_r + 1'b1);
            gap_r <= fall ? '0 : (gap_r < CW'(BURST_GAP_CYC) ? gap_r + 1'b1 : gap_r);
            if (fall) begin
                edges_r <= (gap_r < CW'(BURST_GAP_CYC) && edges_r != 3'(ipc_pkg::BURST_EDGES - 1))
                    ? edges_r + 3'd1 : 3'd1;
            end else if (gap_r >= CW'(BURST_GAP_CYC)) begin
                edges_r <= '0;
            end
        end
    end

    // mode selection; sleep entry accepted whatever powers the supply
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            ipc_pkg::IPC_STARTUP: begin
                if (toggle && ext_ok) mode_nxt = ipc_pkg::IPC_RUN;
            end
            ipc_pkg::IPC_RUN: begin
                if (timed_out) mode_nxt = ipc_pkg::IPC_STARTUP;
            end
            ipc_pkg::IPC_SLEEP: begin
                if (!supply_in.supply_ok) mode_nxt = ipc_pkg::IPC_SLEEP;
                else if (sleep_wake_r && timed_out) mode_nxt = ipc_pkg::IPC_STARTUP;
                else if (sleep_wake_r && toggle && idle_r < CW'(BURST_GAP_CYC * 10))
                    mode_nxt = ipc_pkg::IPC_RUN;
            end
            default: mode_nxt = ipc_pkg::IPC_STARTUP;
        endcase
        if (burst_hit && cmd_valid) mode_nxt = ipc_pkg::IPC_SLEEP;
    end

    // sleep wake tracking: a pulse or a supply drop releases the regulator
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sleep_wake_r <= 1'b0;
        end else if (mode_r != ipc_pkg::IPC_SLEEP || burst_hit) begin
            sleep_wake_r <= 1'b0;
        end else if ((fall && cmd_valid) || !supply_in.supply_ok) begin
            sleep_wake_r <= 1'b1;
        end
    end

    // external gate path
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            run_gate_r <= 1'b0;
        end else if (trip_change || cmd_s2_r) begin
            run_gate_r <= 1'b0;
        end else if (fall) begin
            run_gate_r <= 1'b1;
        end
    end

    // internal current regulator with burst-rate oscillator
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            su_gate_r <= 1'b0;
            off_r <= '0;
            lfo_r <= '0;
            pulses_r <= '0;
        end else if (mode_r != ipc_pkg::IPC_STARTUP) begin
            su_gate_r <= 1'b0;
            off_r <= '0;
            lfo_r <= '0;
            pulses_r <= '0;
        end else begin
            lfo_r <= lfo_wrap ? '0 : lfo_r + 1'b1;
            if (su_gate_r && trip_now) begin
                su_gate_r <= 1'b0;
                off_r <= CW'(OFF_TIME_CYC);
                pulses_r <= pulses_r + 5'd1;
            end else if (off_r != '0) begin
                off_r <= off_r - 1'b1;
            end else if (!su_gate_r && su_window && supply_in.supply_above_upper) begin
                su_gate_r <= 1'b1;
            end
            if (lfo_wrap) pulses_r <= '0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mode_r <= ipc_pkg::IPC_STARTUP;
            gate_out <= 1'b0;
            regulator_enable_out <= 1'b1;
            burst_rate_oscillator_en_out <= 1'b1;
            mode_out <= ipc_pkg::IPC_STARTUP;
        end else begin
            mode_r <= mode_nxt;
            mode_out <= mode_r;
            gate_out <= (mode_r == ipc_pkg::IPC_RUN) ? (run_gate_r & ext_ok) :
                (mode_r == ipc_pkg::IPC_STARTUP) ? su_gate_r : 1'b0;
            regulator_enable_out <= (mode_r != ipc_pkg::IPC_SLEEP) | sleep_wake_r;
            burst_rate_oscillator_en_out <= (mode_r == ipc_pkg::IPC_STARTUP);
        end
    end

    property p_sleep_gate_low;
        @(posedge clk_in) disable iff (sys_rst_in)
        (mode_r == ipc_pkg::IPC_SLEEP) |=> !gate_out;
    endproperty
    a_sleep_gate_low: assert property (p_sleep_gate_low) else $error("gate in sleep");

    property p_trip_ends;
        @(posedge clk_in) disable iff (sys_rst_in)
        trip_change |=> !run_gate_r;
    endproperty
    a_trip_ends: assert property (p_trip_ends) else $error("trip kept on-time");

    property p_lfo_off_run;
        @(posedge clk_in) disable iff (sys_rst_in)
        (mode_r == ipc_pkg::IPC_RUN) |=> !burst_rate_oscillator_en_out;
    endproperty
    a_lfo_off_run: assert property (p_lfo_off_run) else $error("lfo on in run");

    property p_timeout;
        @(posedge clk_in) disable iff (sys_rst_in)
        (mode_r == ipc_pkg::IPC_RUN && timed_out && !burst_hit) |=>
            mode_r == ipc_pkg::IPC_STARTUP;
    endproperty
    a_timeout: assert property (p_timeout) else $error("no return to start-up");

    sequence s_off_start;
        su_gate_r && trip_now && mode_r == ipc_pkg::IPC_STARTUP;
    endsequence
    property p_off_time;
        @(posedge clk_in) disable iff (sys_rst_in)
        s_off_start |=> !su_gate_r [*2];
    endproperty
    a_off_time: assert property (p_off_time) else $error("off-time skipped");

    property p_burst_sleep;
        @(posedge clk_in) disable iff (sys_rst_in)
        (burst_hit && cmd_valid) |=> mode_r == ipc_pkg::IPC_SLEEP;
    endproperty
    a_burst_sleep: assert property (p_burst_sleep) else $error("burst missed");

    property p_ext_needs_reg_off;
        @(posedge clk_in) disable iff (sys_rst_in)
        (mode_r == ipc_pkg::IPC_RUN && supply_in.regulator_on) |=> !gate_out;
    endproperty
    a_ext_needs_reg_off: assert property (p_ext_needs_reg_off) else $error("gate with reg");

    property p_pulse_cap;
        @(posedge clk_in) disable iff (sys_rst_in)
        pulses_r <= 5'(ipc_pkg::BURST_PULSES);
    endproperty
    a_pulse_cap: assert property (p_pulse_cap) else $error("too many pulses");
endmodule // ipc_ctrl

//--- hdl/ipc_pkg.sv
// Purpose: shared constants and types for the isolated command mode controller
// Assumes: 200 MHz system clock
// Notes: times are kept in their own unit, cycle counts derive from them
package ipc_pkg;
    localparam int CLK_MHZ = 200;
    localparam int TIMEOUT_US = 260;
    localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
    localparam int OFF_TIME_US = 21;
    localparam int OFF_TIME_CYC = OFF_TIME_US * CLK_MHZ;
    // a burst edge gap of 2 us at 500 kHz; anything up to 4 us counts as burst spacing
    localparam int BURST_GAP_NS = 4000;
    localparam int BURST_GAP_CYC = BURST_GAP_NS * CLK_MHZ / 1000;
    localparam int BURST_EDGES = 5;
    localparam int BURST_PULSES = 16;
    localparam int LFO_PERIOD_US = 1429;
    localparam int LFO_PERIOD_CYC = LFO_PERIOD_US * CLK_MHZ;

    typedef enum logic [1:0] {
        IPC_STARTUP = 2'b00,
        IPC_RUN = 2'b01,
        IPC_SLEEP = 2'b10
    } ipc_mode_t;

    typedef struct packed {
        logic supply_ok;
        logic supply_above_upper;
        logic regulator_on;
    } ipc_supply_t;
endpackage

//--- tb/ipc_partner.sv
// Purpose: secondary-side controller driving the command line
// Assumes: line is pulled up, so released reads high
// Notes: callers enter on a falling clock edge
`timescale 1ns/1ps
module ipc_partner (
    // clock
    input wire logic clk_in,
    // command line, active low
    output logic cmd_n_out
);
    initial cmd_n_out = 1'b1;
    task automatic pulse(input int lo, input int hi);
        cmd_n_out = 1'b0;
        repeat (lo) @(negedge clk_in);
        cmd_n_out = 1'b1;
        repeat (hi) @(negedge clk_in);
    endtask
    task automatic hold(input logic v);
        cmd_n_out = v;
    endtask
    // falls 4 clocks apart, well inside the burst gap
    task automatic burst();
        repeat (5) pulse(2, 2);
    endtask
endmodule // ipc_partner

//--- tb/tb_ipc_ctrl.sv
// Purpose: self-checking bench for the command mode controller
// Assumes: shortened counts, burst gap 8 clocks, pwm period 40 clocks
// Notes: inputs move and outputs are sampled on the falling edge
`timescale 1ns/1ps
module tb_ipc_ctrl;
    localparam int TMO = 200;
    localparam int OFF = 20;
    localparam int BURST_RATE_OSCILLATOR = 2000;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic peak_limit_trip_in = 1'b0;
    logic ccm_guard_trip_in = 1'b0;
    ipc_pkg::ipc_supply_t supply_in = 3'b100;
    logic cmd_n, gate_out, regulator_enable_out, burst_rate_oscillator_en_out;
    ipc_pkg::ipc_mode_t mode_out;
    int fail_count = 0;
    int compares = 0;
    int gate_hi;
    int low_cyc;
    logic [31:0] seed = 32'h0000_8fd1;
    always #2.5 clk_in = ~clk_in;
    ipc_ctrl #(.TIMEOUT_CYC(TMO), .OFF_TIME_CYC(OFF), .LFO_PERIOD_CYC(BURST_RATE_OSCILLATOR),
        .BURST_GAP_CYC(8)) dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .cmd_n_in(cmd_n), .peak_limit_trip_in(peak_limit_trip_in),
        .ccm_guard_trip_in(ccm_guard_trip_in), .supply_in(supply_in),
        .gate_out(gate_out), .regulator_enable_out(regulator_enable_out),
        .burst_rate_oscillator_en_out(burst_rate_oscillator_en_out),
        .mode_out(mode_out));
    ipc_partner p (.clk_in(clk_in), .cmd_n_out(cmd_n));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic end_of_test();
        if (fail_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task automatic chk_mode(input ipc_pkg::ipc_mode_t got, input ipc_pkg::ipc_mode_t exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t mode %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic wait_mode(input ipc_pkg::ipc_mode_t m, input int n);
        for (int i = 0; i < n && mode_out !== m; i++) @(negedge clk_in);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // random low time, fixed 40 clock period
    task automatic pwm(input int n);
        int lo;
        repeat (n) begin
            seed = xs(seed);
            lo = 8 + int'(seed % 20);
            p.pulse(lo, 40 - lo);
        end
    endtask
    initial begin
        #100us;
        fail_count++;
        end_of_test();
    end
    initial begin
        wait_cyc(2);
        sys_rst_in = 1'b0;
        chk_bit(gate_out, 1'b0, "reset gate");
        chk_bit(regulator_enable_out, 1'b1, "reset regulator");
        chk_bit(burst_rate_oscillator_en_out, 1'b1, "reset oscillator");
        chk_mode(mode_out, ipc_pkg::IPC_STARTUP);
        supply_in.regulator_on = 1'b1;
        pwm(4);
        p.hold(1'b0);
        wait_cyc(10);
        chk_bit(gate_out, 1'b0, "gated with regulator on");
        p.hold(1'b1);
        supply_in.regulator_on = 1'b0;
        // let the released line be seen before the next fall
        wait_cyc(2);
        pwm(6);
        wait_mode(ipc_pkg::IPC_RUN, 10);
        chk_mode(mode_out, ipc_pkg::IPC_RUN);
        chk_bit(burst_rate_oscillator_en_out, 1'b0, "oscillator in run");
        p.hold(1'b0);
        wait_cyc(10);
        chk_bit(gate_out, 1'b1, "gate on low command");
        supply_in.regulator_on = 1'b1;
        wait_cyc(3);
        chk_bit(gate_out, 1'b0, "run gating with regulator on");
        supply_in.regulator_on = 1'b0;
        wait_cyc(3);
        chk_bit(gate_out, 1'b1, "run gating with regulator off");
        peak_limit_trip_in = 1'b1;
        wait_cyc(4);
        chk_bit(gate_out, 1'b0, "trip ends on-time");
        peak_limit_trip_in = 1'b0;
        wait_cyc(TMO + 50);
        chk_mode(mode_out, ipc_pkg::IPC_STARTUP);
        p.hold(1'b1);
        wait_cyc(2);
        pwm(6);
        wait_cyc(10);
        chk_bit(gate_out, 1'b0, "gate off high command");
        wait_cyc(TMO + 50);
        chk_mode(mode_out, ipc_pkg::IPC_STARTUP);
        chk_bit(burst_rate_oscillator_en_out, 1'b1, "oscillator in start-up");
        // start-up regulator: each trip opens a fixed off-time, sixteen per period
        supply_in = 3'b110;
        for (int k = 0; k < ipc_pkg::BURST_PULSES; k++) begin
            for (int i = 0; i < 40 && gate_out !== 1'b1; i++) @(negedge clk_in);
            chk_bit(gate_out, 1'b1, "start-up pulse missing");
            peak_limit_trip_in = 1'b1;
            wait_cyc(1);
            peak_limit_trip_in = 1'b0;
            wait_cyc(1);
            low_cyc = 0;
            while (low_cyc < 3 * OFF && gate_out === 1'b0) begin
                low_cyc++;
                wait_cyc(1);
            end
            if (k < ipc_pkg::BURST_PULSES - 1) begin
                chk_bit(low_cyc >= OFF && low_cyc <= OFF + 2, 1'b1, "off-time length");
            end
        end
        gate_hi = 0;
        repeat (200) begin
            @(negedge clk_in);
            if (gate_out !== 1'b0) gate_hi++;
        end
        chk_bit(gate_hi == 0, 1'b1, "pulse beyond sixteen");
        for (int i = 0; i < BURST_RATE_OSCILLATOR && gate_out !== 1'b1; i++) @(negedge clk_in);
        chk_bit(gate_out, 1'b1, "no pulse after oscillator wrap");
        supply_in = 3'b111;
        p.burst();
        wait_cyc(10);
        chk_mode(mode_out, ipc_pkg::IPC_SLEEP);
        chk_bit(regulator_enable_out, 1'b0, "regulator in sleep");
        gate_hi = 0;
        repeat (100) begin
            seed = xs(seed);
            ccm_guard_trip_in = seed[0];
            peak_limit_trip_in = seed[1];
            supply_in.supply_above_upper = seed[2];
            supply_in.regulator_on = seed[3];
            @(negedge clk_in);
            if (gate_out !== 1'b0) gate_hi++;
        end
        chk_bit(gate_hi == 0, 1'b1, "gating in sleep");
        ccm_guard_trip_in = 1'b0;
        peak_limit_trip_in = 1'b0;
        supply_in = 3'b100;
        pwm(6);
        wait_mode(ipc_pkg::IPC_RUN, 20);
        chk_mode(mode_out, ipc_pkg::IPC_RUN);
        p.burst();
        wait_cyc(10);
        chk_mode(mode_out, ipc_pkg::IPC_SLEEP);
        p.pulse(20, 2);
        wait_mode(ipc_pkg::IPC_STARTUP, TMO + 300);
        chk_mode(mode_out, ipc_pkg::IPC_STARTUP);
        supply_in.supply_ok = 1'b0;
        p.burst();
        wait_cyc(10);
        chk_bit(regulator_enable_out, 1'b1, "sleep with supply low");
        chk_bit(mode_out !== ipc_pkg::IPC_SLEEP, 1'b1, "sleep taken below lockout");
        end_of_test();
    end
endmodule // tb_ipc_ctrl
